/* File: logic/abx_exec_unit.v */
// execution datapath: register file, status flags, program counter
`timescale 1ns/100ps
`default_nettype none
`include "abx_consts.vh"
module abx_exec_unit (
   input wire core_clk,
   input wire rst_b,
   input wire op_valid,
   output wire op_ready,
   input wire [4:0] op_code,
   input wire [4:0] op_dst,
   input wire [4:0] op_src,
   input wire [7:0] op_imm,
   input wire [1:0] op_pair,
   input wire [2:0] op_bit,
   input wire [15:0] op_target,
   input wire next_two_word,
   output reg op_done_q,
   output reg [15:0] pc_q,
   output reg [7:0] sreg_q,
   output reg push_valid_q,
   output reg [15:0] push_addr_q,
   input wire ext_wr_en,
   input wire [4:0] ext_wr_addr,
   input wire [7:0] ext_wr_data,
   input wire [4:0] rd_addr,
   output reg [7:0] rd_data_q
);
   // =========================================================
   // state
   // =========================================================
   reg [7:0] rf_q [0:31];
   reg [1:0] busy_q;
   integer i;

   wire accept;
   assign op_ready = (busy_q == 2'h0);
   assign accept = op_valid && op_ready;

   // =========================================================
   // operand selection
   // =========================================================
   reg [7:0] opa;
   reg [7:0] opb;
   reg add_cin;
   reg add_sub;
   wire [7:0] add_res;
   wire add_c;
   wire add_h;
   wire add_v;

   wire [4:0] pair_lo;
   wire [4:0] pair_hi;
   wire [15:0] word_in;
   wire [16:0] word_sum;
   wire [16:0] word_dif;
   wire [15:0] ptr;
   wire [15:0] rel_target;
   wire [15:0] pc_inc;

   assign pair_lo = {`ABX_PAIR_BASE, op_pair, 1'b0};
   assign pair_hi = {`ABX_PAIR_BASE, op_pair, 1'b1};
   assign word_in = {rf_q[pair_hi], rf_q[pair_lo]};
   // immediate range of the word forms is 0..63
   assign word_sum = {1'b0, word_in} + {11'h000, op_imm[5:0]};
   assign word_dif = {1'b0, word_in} - {11'h000, op_imm[5:0]};
   assign ptr = {rf_q[`ABX_PTR_HI], rf_q[`ABX_PTR_LO]};
   assign rel_target = pc_q + {{4{op_target[11]}}, op_target[11:0]} +
      16'h0001;
   assign pc_inc = pc_q + 16'h0001;

   always @* begin
      opa = rf_q[op_dst];
      opb = rf_q[op_src];
      add_cin = 1'b0;
      add_sub = 1'b0;
      case (op_code)
         `ABX_OP_SUM_CARRY: begin
            add_cin = sreg_q[`ABX_FLAG_C];
         end
         `ABX_OP_DIFF, `ABX_OP_MAG: begin
            add_sub = 1'b1;
         end
         `ABX_OP_DIFF_IMM, `ABX_OP_MAG_IMM: begin
            opb = op_imm;
            add_sub = 1'b1;
         end
         `ABX_OP_BORROW, `ABX_OP_MAG_CARRY: begin
            add_sub = 1'b1;
            add_cin = sreg_q[`ABX_FLAG_C];
         end
         `ABX_OP_BORROW_IMM: begin
            opb = op_imm;
            add_sub = 1'b1;
            add_cin = sreg_q[`ABX_FLAG_C];
         end
         `ABX_OP_PLUS_ONE: begin
            opb = 8'h01;
         end
         `ABX_OP_MINUS_ONE: begin
            opb = 8'h01;
            add_sub = 1'b1;
         end
         default: begin
            opb = rf_q[op_src];
         end
      endcase
   end

   abx_byte_adder u_adder (
      .a(opa),
      .b(opb),
      .cin(add_cin),
      .sub(add_sub),
      .res(add_res),
      .c(add_c),
      .h(add_h),
      .v(add_v)
   );

   // =========================================================
   // result, flags, program counter and cycle count
   // =========================================================
   reg [7:0] res;
   reg wr_byte;
   reg wr_word;
   reg [15:0] word_res;
   reg [7:0] sreg_d;
   reg [15:0] pc_d;
   reg [2:0] cycles;
   reg push;
   reg [15:0] push_addr;
   reg skip;

   // write Z,N,V of a byte result with the given V; others untouched
   task set_znv;
      input [7:0] r;
      input vv;
      begin
         sreg_d[`ABX_FLAG_Z] = (r == 8'h00);
         sreg_d[`ABX_FLAG_N] = r[7];
         sreg_d[`ABX_FLAG_V] = vv;
      end
   endtask

   always @* begin
      res = add_res;
      wr_byte = 1'b0;
      wr_word = 1'b0;
      word_res = word_sum[15:0];
      sreg_d = sreg_q;
      pc_d = pc_inc;
      cycles = {1'b0, `ABX_CYC_ALU};
      push = 1'b0;
      push_addr = pc_inc;
      skip = 1'b0;
      case (op_code)
         `ABX_OP_SUM, `ABX_OP_SUM_CARRY, `ABX_OP_DIFF, `ABX_OP_DIFF_IMM,
         `ABX_OP_BORROW, `ABX_OP_BORROW_IMM: begin
            wr_byte = 1'b1;
            set_znv(add_res, add_v);
            sreg_d[`ABX_FLAG_C] = add_c;
            sreg_d[`ABX_FLAG_H] = add_h;
         end
         `ABX_OP_MAG, `ABX_OP_MAG_CARRY, `ABX_OP_MAG_IMM: begin
            set_znv(add_res, add_v);
            sreg_d[`ABX_FLAG_C] = add_c;
            sreg_d[`ABX_FLAG_H] = add_h;
         end
         `ABX_OP_WORD_SUM: begin
            wr_word = 1'b1;
            cycles = {1'b0, `ABX_CYC_WORD};
            sreg_d[`ABX_FLAG_Z] = (word_sum[15:0] == 16'h0000);
            sreg_d[`ABX_FLAG_N] = word_sum[15];
            sreg_d[`ABX_FLAG_V] = ~word_in[15] & word_sum[15];
            sreg_d[`ABX_FLAG_C] = word_in[15] & ~word_sum[15];
            sreg_d[`ABX_FLAG_S] = word_sum[15] ^
               (~word_in[15] & word_sum[15]);
         end
         `ABX_OP_WORD_DIFF: begin
            wr_word = 1'b1;
            word_res = word_dif[15:0];
            cycles = {1'b0, `ABX_CYC_WORD};
            sreg_d[`ABX_FLAG_Z] = (word_dif[15:0] == 16'h0000);
            sreg_d[`ABX_FLAG_N] = word_dif[15];
            sreg_d[`ABX_FLAG_V] = word_in[15] & ~word_dif[15];
            sreg_d[`ABX_FLAG_C] = word_dif[15] & ~word_in[15];
            sreg_d[`ABX_FLAG_S] = word_dif[15] ^
               (word_in[15] & ~word_dif[15]);
         end
         `ABX_OP_AND, `ABX_OP_AND_IMM, `ABX_OP_ZERO_SIGN: begin
            if (op_code == `ABX_OP_AND_IMM) begin
               res = opa & op_imm;
            end else if (op_code == `ABX_OP_ZERO_SIGN) begin
               res = opa & opa;
            end else begin
               res = opa & opb;
            end
            wr_byte = (op_code != `ABX_OP_ZERO_SIGN);
            set_znv(res, 1'b0);
         end
         `ABX_OP_OR, `ABX_OP_OR_IMM, `ABX_OP_MASK_SET: begin
            res = opa | ((op_code == `ABX_OP_OR) ? opb : op_imm);
            wr_byte = 1'b1;
            set_znv(res, 1'b0);
         end
         `ABX_OP_XOR, `ABX_OP_ZEROING: begin
            // zeroing reads the destination as both operands
            res = opa ^ ((op_code == `ABX_OP_ZEROING) ? opa : opb);
            wr_byte = 1'b1;
            set_znv(res, 1'b0);
         end
         `ABX_OP_MASK_CLEAR: begin
            res = opa & (`ABX_BYTE_ONES - op_imm);
            wr_byte = 1'b1;
            set_znv(res, 1'b0);
         end
         `ABX_OP_INVERT: begin
            res = `ABX_BYTE_ONES - opa;
            wr_byte = 1'b1;
            set_znv(res, 1'b0);
            sreg_d[`ABX_FLAG_C] = 1'b1;
         end
         `ABX_OP_PLUS_ONE, `ABX_OP_MINUS_ONE: begin
            wr_byte = 1'b1;
            set_znv(add_res, add_v);
         end
         `ABX_OP_ABS_BRANCH: begin
            pc_d = op_target;
            cycles = {1'b0, `ABX_CYC_ABS_BRANCH};
         end
         `ABX_OP_REL_BRANCH: begin
            pc_d = rel_target;
            cycles = {1'b0, `ABX_CYC_REL_BRANCH};
         end
         `ABX_OP_PTR_BRANCH: begin
            pc_d = ptr;
            cycles = {1'b0, `ABX_CYC_PTR_BRANCH};
         end
         `ABX_OP_ABS_CALL: begin
            // the absolute form is two words long, so return lands past both
            pc_d = op_target;
            push = 1'b1;
            push_addr = pc_q + 16'h0002;
            cycles = `ABX_CYC_ABS_CALL;
         end
         `ABX_OP_REL_CALL: begin
            pc_d = rel_target;
            push = 1'b1;
            cycles = {1'b0, `ABX_CYC_REL_CALL};
         end
         `ABX_OP_PTR_CALL: begin
            pc_d = ptr;
            push = 1'b1;
            cycles = {1'b0, `ABX_CYC_PTR_CALL};
         end
         `ABX_OP_EQUAL_SKIP: begin
            skip = (opa == opb);
         end
         `ABX_OP_BIT_CLR_SKIP: begin
            skip = ~opa[op_bit];
         end
         default: begin
            pc_d = pc_inc;
         end
      endcase
      if (skip) begin
         if (next_two_word) begin
            pc_d = pc_q + 16'h0003;
            cycles = {1'b0, `ABX_CYC_SKIP_TWO};
         end else begin
            pc_d = pc_q + 16'h0002;
            cycles = {1'b0, `ABX_CYC_SKIP_ONE};
         end
      end
   end

   // =========================================================
   // commit at the accepting edge, then stall for the rest
   // =========================================================
   // results land at once; the stall only holds the cycle count so that
   // the next operation always sees the committed state
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (i = 0; i < 32; i = i + 1) begin
            rf_q[i] <= `ABX_REG_RST;
         end
         busy_q <= 2'h0;
         op_done_q <= 1'b0;
         pc_q <= `ABX_PC_RST;
         sreg_q <= `ABX_SREG_RST;
         push_valid_q <= 1'b0;
         push_addr_q <= 16'h0000;
         rd_data_q <= 8'h00;
      end else begin
         rd_data_q <= rf_q[rd_addr];
         push_valid_q <= accept && push;
         if (accept) begin
            sreg_q <= sreg_d;
            pc_q <= pc_d;
            busy_q <= cycles[1:0] - 2'h1;
            if (cycles == 3'h4) begin
               busy_q <= 2'h3;
            end
            op_done_q <= (cycles == 3'h1);
            if (push) begin
               push_addr_q <= push_addr;
            end
            if (wr_byte) begin
               rf_q[op_dst] <= res;
            end
            if (wr_word) begin
               rf_q[pair_lo] <= word_res[7:0];
               rf_q[pair_hi] <= word_res[15:8];
            end
         end else begin
            if (busy_q != 2'h0) begin
               busy_q <= busy_q - 2'h1;
            end
            op_done_q <= (busy_q == 2'h1);
            // side writes only land while no operation is taken
            if (ext_wr_en) begin
               rf_q[ext_wr_addr] <= ext_wr_data;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: logic/abx_consts.vh */
// constants for the abx execution unit: operation codes, flags, cycle counts
`ifndef ABX_CONSTS_VH
`define ABX_CONSTS_VH

// operation codes, 5 bits
`define ABX_OP_SUM            5'h00
`define ABX_OP_SUM_CARRY      5'h01
`define ABX_OP_WORD_SUM       5'h02
`define ABX_OP_DIFF           5'h03
`define ABX_OP_DIFF_IMM       5'h04
`define ABX_OP_BORROW         5'h05
`define ABX_OP_BORROW_IMM     5'h06
`define ABX_OP_WORD_DIFF      5'h07
`define ABX_OP_AND            5'h08
`define ABX_OP_AND_IMM        5'h09
`define ABX_OP_OR             5'h0A
`define ABX_OP_OR_IMM         5'h0B
`define ABX_OP_XOR            5'h0C
`define ABX_OP_INVERT         5'h0D
`define ABX_OP_MASK_SET       5'h0E
`define ABX_OP_MASK_CLEAR     5'h0F
`define ABX_OP_PLUS_ONE       5'h10
`define ABX_OP_MINUS_ONE      5'h11
`define ABX_OP_ZERO_SIGN      5'h12
`define ABX_OP_ZEROING        5'h13
`define ABX_OP_ABS_BRANCH     5'h14
`define ABX_OP_REL_BRANCH     5'h15
`define ABX_OP_PTR_BRANCH     5'h16
`define ABX_OP_ABS_CALL       5'h17
`define ABX_OP_REL_CALL       5'h18
`define ABX_OP_PTR_CALL       5'h19
`define ABX_OP_EQUAL_SKIP     5'h1A
`define ABX_OP_MAG            5'h1B
`define ABX_OP_MAG_CARRY      5'h1C
`define ABX_OP_MAG_IMM        5'h1D
`define ABX_OP_BIT_CLR_SKIP   5'h1E

// status flag bit positions
`define ABX_FLAG_C 0
`define ABX_FLAG_Z 1
`define ABX_FLAG_N 2
`define ABX_FLAG_V 3
`define ABX_FLAG_S 4
`define ABX_FLAG_H 5

// reset values
`define ABX_SREG_RST 8'h00
`define ABX_PC_RST 16'h0000
`define ABX_REG_RST 8'h00

// cycle counts per operation
`define ABX_CYC_ALU 2'h1
`define ABX_CYC_WORD 2'h2
`define ABX_CYC_ABS_BRANCH 2'h3
`define ABX_CYC_REL_BRANCH 2'h2
`define ABX_CYC_PTR_BRANCH 2'h2
`define ABX_CYC_ABS_CALL 3'h4
`define ABX_CYC_REL_CALL 2'h3
`define ABX_CYC_PTR_CALL 2'h3
`define ABX_CYC_NO_SKIP 2'h1
`define ABX_CYC_SKIP_ONE 2'h2
`define ABX_CYC_SKIP_TWO 2'h3

// register file layout
`define ABX_PAIR_BASE 2'h3
`define ABX_PTR_LO 5'h1E
`define ABX_PTR_HI 5'h1F
`define ABX_BYTE_ONES 8'hFF

`endif

/* File: logic/abx_byte_adder.v */
// 8-bit adder/subtractor with carry, half-carry and overflow outputs
`timescale 1ns/100ps
`default_nettype none
module abx_byte_adder (
   input wire [7:0] a,
   input wire [7:0] b,
   input wire cin,
   input wire sub,
   output wire [7:0] res,
   output wire c,
   output wire h,
   output wire v
);
   wire [7:0] b_eff;
   wire cin_eff;
   wire [8:0] sum;
   wire [4:0] low;

   // subtract as a + ~b + ~borrow, then invert carries back to borrows
   assign b_eff = sub ? ~b : b;
   assign cin_eff = sub ? ~cin : cin;
   assign sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin_eff};
   assign low = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
   assign res = sum[7:0];
   assign c = sub ? ~sum[8] : sum[8];
   assign h = sub ? ~low[4] : low[4];
   assign v = (a[7] == b_eff[7]) && (sum[7] != a[7]);
endmodule
`default_nettype wire

/* File: tb/abx_exec_unit_assertions.sv */
// checker: timing and flag properties of the execution unit
`timescale 1ns/100ps
`default_nettype none
`include "abx_consts.vh"
// ==========
// checker
module abx_exec_unit_chk (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic op_valid,
   input wire logic op_ready,
   input wire logic [4:0] op_code,
   input wire logic [15:0] op_target,
   input wire logic next_two_word,
   input wire logic op_done_q,
   input wire logic [15:0] pc_q,
   input wire logic [7:0] sreg_q,
   input wire logic push_valid_q,
   input wire logic [15:0] push_addr_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   wire logic tk = op_valid && op_ready;
   a_byte_single: assert property (
      tk && op_code <= `ABX_OP_SUM_CARRY |=> op_done_q && op_ready)
      else $error("byte sum not done in one cycle");
   a_word_two: assert property (
      tk && (op_code == `ABX_OP_WORD_SUM || op_code == `ABX_OP_WORD_DIFF)
      |=> !op_ready ##1 op_ready && op_done_q)
      else $error("word op not two cycles");
   a_abs_branch: assert property (
      tk && op_code == `ABX_OP_ABS_BRANCH |=> pc_q == $past(op_target)
      && !op_ready ##1 !op_ready ##1 op_ready)
      else $error("absolute branch target or length wrong");
   a_rel_target: assert property (
      tk && op_code == `ABX_OP_REL_BRANCH |=> pc_q == $past(pc_q) + 16'h1
      + {{4{$past(op_target[11])}}, $past(op_target[11:0])})
      else $error("relative branch target wrong");
   a_call_push: assert property (
      tk && op_code == `ABX_OP_ABS_CALL |=> push_valid_q
      && push_addr_q == $past(pc_q) + 16'h2 ##0 (!op_ready)[*3] ##1 op_ready)
      else $error("absolute call push or length wrong");
   a_short_call: assert property (
      tk && (op_code == `ABX_OP_REL_CALL || op_code == `ABX_OP_PTR_CALL)
      |=> push_valid_q && push_addr_q == $past(pc_q) + 16'h1
      ##0 (!op_ready)[*2] ##1 op_ready)
      else $error("short call push or length wrong");
   a_skip_span: assert property (
      tk && next_two_word && (op_code == `ABX_OP_EQUAL_SKIP
      || op_code == `ABX_OP_BIT_CLR_SKIP) |=>
      (pc_q == $past(pc_q) + 16'h1 && op_ready) or
      (pc_q == $past(pc_q) + 16'h3 ##0 (!op_ready)[*2] ##1 op_ready))
      else $error("skip distance and length disagree");
   a_flow_flags: assert property (
      tk && op_code >= `ABX_OP_ABS_BRANCH && op_code <= `ABX_OP_EQUAL_SKIP
      |=> $stable(sreg_q))
      else $error("flow op changed flags");
   a_zeroing: assert property (
      tk && op_code == `ABX_OP_ZEROING |=> sreg_q[3:1] == 3'b001
      && sreg_q[0] == $past(sreg_q[0]))
      else $error("zeroing flags wrong");
endmodule
bind abx_exec_unit abx_exec_unit_chk abx_exec_unit_chk_i (.core_clk, .rst_b,
   .op_valid, .op_ready, .op_code, .op_target, .next_two_word, .op_done_q,
   .pc_q, .sreg_q, .push_valid_q, .push_addr_q);
`default_nettype wire

/* File: tb/abx_exec_unit_tb_top.sv */
// self-checking bench for the execution unit
`timescale 1ns/100ps
`default_nettype none
`include "abx_consts.vh"
// ==========
// bench
module abx_exec_unit_tb_top;
   logic core_clk = 0, rst_b = 0, op_valid = 0, next_two_word = 0;
   logic ext_wr_en = 0, op_ready, op_done_q, push_valid_q;
   logic [4:0] op_code = 0, op_dst = 0, op_src = 0, ext_wr_addr = 0;
   logic [4:0] rd_addr = 0;
   logic [7:0] op_imm = 0, ext_wr_data = 0, f = 0, rd_data_q, sreg_q;
   logic [1:0] op_pair = 0;
   logic [2:0] op_bit = 0;
   logic [15:0] op_target = 0, pc = 0, pc_q, push_addr_q;
   logic [7:0] m [0:31];
   logic [32:0] exq [$];
   logic [32:0] e;
   int n_mismatch = 0, comparisons = 0, seed = 57, i, r;
   always #5 core_clk = ~core_clk;
   abx_exec_unit abx_exec_unit_i (.core_clk, .rst_b, .op_valid, .op_ready,
      .op_code, .op_dst, .op_src, .op_imm, .op_pair, .op_bit, .op_target,
      .next_two_word, .op_done_q, .pc_q, .sreg_q, .push_valid_q,
      .push_addr_q, .ext_wr_en, .ext_wr_addr, .ext_wr_data, .rd_addr,
      .rd_data_q);
   task automatic check(input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========
   // reference model
   task automatic model;
      logic [7:0] a, b, x, nf, ms;
      logic [16:0] w;
      logic [4:0] lo;
      logic cy, st;
      a = m[op_dst];
      lo = {2'b11, op_pair, 1'b0};
      b = op_code inside {`ABX_OP_DIFF_IMM, `ABX_OP_BORROW_IMM,
         `ABX_OP_AND_IMM, `ABX_OP_OR_IMM, `ABX_OP_MASK_SET,
         `ABX_OP_MASK_CLEAR, `ABX_OP_MAG_IMM} ? op_imm : m[op_src];
      cy = f[0] && op_code inside {`ABX_OP_SUM_CARRY, `ABX_OP_BORROW,
         `ABX_OP_BORROW_IMM, `ABX_OP_MAG_CARRY};
      {ms, st, nf, x, rd_addr} = {8'h2F, 1'b1, 8'h00, a, op_dst};
      pc = pc + 16'h1;
      case (op_code)
         `ABX_OP_SUM, `ABX_OP_SUM_CARRY: begin
            x = a + b + cy;
            nf[0] = {1'b0, a} + b + cy > 9'h0FF;
            nf[5] = a[3:0] + b[3:0] + cy > 5'h0F;
            nf[3] = a[7] == b[7] && x[7] != a[7];
         end
         `ABX_OP_DIFF, `ABX_OP_DIFF_IMM, `ABX_OP_BORROW, `ABX_OP_BORROW_IMM,
         `ABX_OP_MAG, `ABX_OP_MAG_CARRY, `ABX_OP_MAG_IMM: begin
            x = a - b - cy;
            nf[0] = {1'b0, a} < {1'b0, b} + cy;
            nf[5] = {1'b0, a[3:0]} < {1'b0, b[3:0]} + cy;
            nf[3] = a[7] != b[7] && x[7] != a[7];
            st = op_code < `ABX_OP_MAG;
         end
         `ABX_OP_AND, `ABX_OP_AND_IMM: {x, ms} = {a & b, 8'h0E};
         `ABX_OP_ZERO_SIGN: ms = 8'h0E;
         `ABX_OP_OR, `ABX_OP_OR_IMM, `ABX_OP_MASK_SET:
            {x, ms} = {a | b, 8'h0E};
         `ABX_OP_XOR: {x, ms} = {a ^ b, 8'h0E};
         `ABX_OP_ZEROING: {x, ms} = {8'h00, 8'h0E};
         `ABX_OP_MASK_CLEAR: {x, ms} = {a & ~b, 8'h0E};
         `ABX_OP_INVERT: {x, ms, nf[0]} = {~a, 8'h0F, 1'b1};
         `ABX_OP_PLUS_ONE, `ABX_OP_MINUS_ONE: begin
            x = op_code == `ABX_OP_PLUS_ONE ? a + 8'h01 : a - 8'h01;
            {ms, nf[3]} = {8'h0E, x == (op_code[0] ? 8'h7F : 8'h80)};
         end
         `ABX_OP_WORD_SUM, `ABX_OP_WORD_DIFF: begin
            a = m[lo + 5'h01];
            w = {1'b0, a, m[lo]};
            w = op_code[0] ? w - op_imm[5:0] : w + op_imm[5:0];
            nf[3] = op_code[0] ? a[7] && !w[15] : !a[7] && w[15];
            nf[2:0] = {w[15], w[15:0] == 16'h0000, w[16]};
            nf[4] = nf[3] ^ nf[2];
            {ms, x, rd_addr} = {8'h1F, w[7:0], lo};
            m[lo + 5'h01] = w[15:8];
         end
         `ABX_OP_ABS_BRANCH, `ABX_OP_ABS_CALL:
            {pc, ms, st} = {op_target, 9'h000};
         `ABX_OP_REL_BRANCH, `ABX_OP_REL_CALL:
            {pc, ms, st} = {pc + {{4{op_target[11]}}, op_target[11:0]}, 9'h0};
         `ABX_OP_PTR_BRANCH, `ABX_OP_PTR_CALL:
            {pc, ms, st} = {m[31], m[30], 9'h000};
         `ABX_OP_EQUAL_SKIP, `ABX_OP_BIT_CLR_SKIP: begin
            {ms, st} = 9'h000;
            // both skip codes are even, so decode the bit form by its code
            if (op_code == `ABX_OP_BIT_CLR_SKIP ? !a[op_bit] : a == b)
               pc = pc + (next_two_word ? 16'h0002 : 16'h0001);
         end
         default: {ms, st} = 9'h000;
      endcase
      if (ms != 8'h1F)
         nf[2:1] = {x[7], x == 8'h00};
      f = (f & ~ms) | (nf & ms);
      if (st)
         m[rd_addr] = x;
      exq.push_back({st, x, f, pc});
   endtask
   task automatic issue(input logic [4:0] c);
      int n;
      @(negedge core_clk);
      r = $random(seed);
      {op_dst, op_src, op_imm, op_pair, op_bit, next_two_word} = r[23:0];
      if (r[24])
         op_src = op_dst;
      // side write in the taking cycle is dropped, so the model ignores it
      {ext_wr_en, ext_wr_addr, ext_wr_data} = {r[25], r[30:26], r[31:24]};
      op_target = 16'($random(seed));
      op_code = c;
      model();
      op_valid = 1;
      @(negedge core_clk);
      {op_valid, ext_wr_en} = 2'b00;
      for (n = 0; n < 8 && op_ready !== 1'b1; n++)
         @(negedge core_clk);
      if (n == 8)
         n_mismatch++;
   endtask
   // ==========
   // result watcher
   always @(negedge core_clk) begin
      if (rst_b === 1'b1 && op_done_q === 1'b1) begin
         e = exq.pop_front();
         check(pc_q, e[15:0]);
         check({8'h00, sreg_q}, {8'h00, e[23:16]});
         if (e[32]) begin
            @(negedge core_clk);
            check({8'h00, rd_data_q}, {8'h00, e[31:24]});
         end
      end
   end
   initial begin
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      rst_b = 1;
      check(pc_q, 16'h0000);
      check({sreg_q, rd_data_q}, 16'h0000);
      for (i = 0; i < 32; i++) begin
         @(negedge core_clk);
         r = $random(seed);
         {ext_wr_en, ext_wr_addr, ext_wr_data} = {1'b1, i[4:0], r[7:0]};
         m[i] = r[7:0];
      end
      for (i = 0; i < 400; i++)
         issue(i < 32 ? i[4:0] : 5'($random(seed)));
      repeat (3) @(negedge core_clk);
      check(16'(exq.size()), 16'h0000);
      conclude();
   end
   initial begin
      #100000;
      n_mismatch++;
      conclude();
   end
endmodule
`default_nettype wire
